// file: core/ccfg_pkg.sv
// Package of constants and types for the clock and protection config decoder
//
// Contract
// - Clock word bit 15 one enables two-speed start-up, zero disables it.
// - Watchdog mux bit zero forces low-power RC; one follows watchdog clock select.
// - Initial oscillator field selects the reset clock; code 110 is reserved.
// - Switch field: 1x none, 01 switching only, 00 switching plus fail-safe.
// - With primary mode 11 or 00, pin bit one gives half-rate clock out.
// - Watchdog select: 11 LOW_POWER_RC_OSC, 10 fast RC or LOW_POWER_RC_OSC, 01 secondary, 00 system.
// - Code 10 uses 31 kHz fast RC only in windowed mode, LOW_POWER_RC_OSC not system.
// - Primary mode: 11 off, 10 high-speed crystal, 01 crystal, 00 external clock.
// - Segment end one protects boundary to last page; zero protects zero to boundary.
// - Config page protect zero with segments enabled protects last page and words.
// - With segments enabled, segment end one or boundary at config page always protects that page.
// - Segment disable one turns protection off; zero enforces the defined segment.
// - Brown-out bit one enables brown-out reset except in Deep Sleep.
// - PLL feed bit: one primary oscillator, zero fast RC; only when PLL unused.
// - Window width: 11 25, 10 37.5, 01 50, 00 75 percent.
// - Secondary select one uses crystal; zero is digital clock input mode.
// - Boundary field counts 512-word pages; address is field times page size.
// - Alternate comparator bit one puts C inputs on B13, B9, A0; else B9.
// - Bits 23 to 16 of both words read back as one.
// - Every device reset reloads both words from the top of program memory.
package ccfg_pkg;

	// Word layout
	localparam int CW_WIDTH = 24;
	localparam int ADDR_WIDTH = 24;
	localparam logic [7:0] UNIMPL_ONES = 8'hFF;

	// Clock word fields
	localparam int CK_TWO_SPEED = 15;
	localparam int CK_WDOG_MUX = 13;
	localparam int CK_ALT_CMP = 12;
	localparam int CK_OSC_LSB = 8;
	localparam int CK_SWITCH_LSB = 6;
	localparam int CK_OSC_PIN = 5;
	localparam int CK_WDCLK_LSB = 3;
	localparam int CK_POSC_LSB = 0;

	// Protection word fields
	localparam int WP_END = 15;
	localparam int WP_CFG = 14;
	localparam int WP_DIS = 13;
	localparam int WP_BOR = 12;
	localparam int WP_PLL_FEED_SELECT = 11;
	localparam int WP_WIN_LSB = 9;
	localparam int WP_SECONDARY_OSC = 8;
	localparam int WP_PAGE_LSB = 0;
	localparam int PAGE_BITS = 7;

	// Pages hold 512 instruction words, two address units each
	localparam int PAGE_WORDS = 512;
	localparam int PAGE_SHIFT = 10;

	// Default flash locations of the two words (large variant)
	localparam logic [23:0] CLOCK_WORD_ADDR = 24'h0157FC;
	localparam logic [23:0] PROT_WORD_ADDR = 24'h0157FA;
	localparam logic [6:0] LAST_PAGE = 7'h55;

	// Port pin codes for comparator C inputs
	localparam logic [1:0] PIN_B9 = 2'h0;
	localparam logic [1:0] PIN_B13 = 2'h1;
	localparam logic [1:0] PIN_A0 = 2'h2;

	// Window in eighths of the period
	localparam logic [2:0] WIN_25 = 3'h2;
	localparam logic [2:0] WIN_37 = 3'h3;
	localparam logic [2:0] WIN_50 = 3'h4;
	localparam logic [2:0] WIN_75 = 3'h6;

	typedef enum logic [2:0] {
		CCFG_OSC_FRC, CCFG_OSC_FRC_PLL, CCFG_OSC_PRI, CCFG_OSC_PRI_PLL,
		CCFG_OSC_SEC, CCFG_OSC_LOW_POWER_RC_OSC, CCFG_OSC_RSVD, CCFG_OSC_FRC_DIV
	} ccfg_osc_t;

	typedef enum logic [1:0] {
		CCFG_PRI_EXT, CCFG_PRI_XT, CCFG_PRI_HS, CCFG_PRI_OFF
	} ccfg_pri_t;

	typedef enum logic [1:0] {
		CCFG_WD_LOW_POWER_RC_OSC, CCFG_WD_FRC31, CCFG_WD_SEC, CCFG_WD_SYS
	} ccfg_wdclk_t;

	// Clock-side decoded settings
	typedef struct packed {
		logic two_speed_startup_en;
		ccfg_osc_t initial_osc_sel;
		logic osc_reserved;
		logic clock_switch_en;
		logic fail_safe_en;
		logic clock_out_en;
		ccfg_pri_t primary_osc_mode;
		logic secondary_osc_crystal;
		logic pll_feed_primary;
	} ccfg_clk_t;

	// Protection-side decoded settings
	typedef struct packed {
		logic protect_en;
		logic [23:0] low_addr;
		logic [23:0] high_addr;
		logic config_page_protected;
		logic brownout_reset_en;
	} ccfg_prot_t;

	// Comparator C input placement
	typedef struct packed {
		logic [1:0] comparator1_c_input;
		logic [1:0] comparator2_c_input;
		logic [1:0] comparator3_c_input;
	} ccfg_cmp_t;

endpackage

// file: core/ccfg_decode.sv
// Reset-time loader and decoder of the clock and protection config words
`timescale 1ns/1ps
`default_nettype none
module ccfg_decode
	import ccfg_pkg::*;
(
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// Flash read port
	output logic [ADDR_WIDTH-1:0] O_FLASH_ADDR,
	output logic O_FLASH_RD,
	input wire logic [CW_WIDTH-1:0] I_FLASH_DATA,
	input wire logic I_FLASH_VALID,
	// Run-time watchdog and PLL context
	input wire logic I_SLEEP,
	input wire logic I_WDOG_WINDOWED,
	input wire logic I_SYS_CLK_IS_LOW_POWER_RC_OSC,
	input wire logic I_PLL_IN_USE,
	// Loaded words read back and load-done flag
	output logic [CW_WIDTH-1:0] O_CLOCK_WORD,
	output logic [CW_WIDTH-1:0] O_PROT_WORD,
	output logic O_LOAD_DONE,
	// Decoded settings
	output ccfg_clk_t O_CLK_CFG,
	output ccfg_prot_t O_PROT_CFG,
	output ccfg_cmp_t O_CMP_CFG,
	output ccfg_wdclk_t O_WDOG_CLK,
	output logic [2:0] O_WDOG_WINDOW,
	output logic O_PLL_FEED_PRIMARY
);

	typedef enum logic [1:0] {ST_CLOCK, ST_PROT, ST_DONE} ccfg_state_t;

	ccfg_state_t state;
	logic [15:0] clock_word;
	logic [15:0] prot_word;
	logic [2:0] osc_code;
	logic [1:0] switch_code;
	logic [1:0] posc_code;
	logic [1:0] wdclk_code;
	logic [1:0] win_code;
	logic [PAGE_BITS-1:0] page;
	logic pll_feed;
	ccfg_clk_t next_clk;
	ccfg_prot_t next_prot;
	ccfg_cmp_t next_cmp;
	logic load_done_q;

	// Load sequencer: restarts on every reset, one read per word
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			state <= ST_CLOCK;
		end else begin
			unique case (state)
				ST_CLOCK: if (I_FLASH_VALID) state <= ST_PROT;
				ST_PROT: if (I_FLASH_VALID) state <= ST_DONE;
				ST_DONE: state <= ST_DONE;
			endcase
		end
	end

	// Raw word capture; erased flash reads as ones, so that is the reset value
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			clock_word <= 16'hFFFF;
			prot_word <= 16'hFFFF;
		end else if (I_FLASH_VALID) begin
			if (state == ST_CLOCK)
				clock_word <= I_FLASH_DATA[15:0];
			else if (state == ST_PROT)
				prot_word <= I_FLASH_DATA[15:0];
		end
	end

	// Flash requests are held until the array answers
	assign O_FLASH_RD = (state != ST_DONE);
	assign O_FLASH_ADDR = (state == ST_PROT) ? PROT_WORD_ADDR : CLOCK_WORD_ADDR;
	assign O_LOAD_DONE = (state == ST_DONE);

	// Upper byte is unimplemented and always reads as ones
	assign O_CLOCK_WORD = {UNIMPL_ONES, clock_word};
	assign O_PROT_WORD = {UNIMPL_ONES, prot_word};

	// Field extraction
	assign osc_code = clock_word[CK_OSC_LSB +: 3];
	assign switch_code = clock_word[CK_SWITCH_LSB +: 2];
	assign posc_code = clock_word[CK_POSC_LSB +: 2];
	assign wdclk_code = clock_word[CK_WDCLK_LSB +: 2];
	assign win_code = prot_word[WP_WIN_LSB +: 2];
	assign page = prot_word[WP_PAGE_LSB +: PAGE_BITS];
	// Reserved bits (clock 11 and 2, protection 7) are not decoded
	// Top page bit is used as loaded; small parts keep it zero

	// Clock settings decode
	always_comb begin
		next_clk.two_speed_startup_en = clock_word[CK_TWO_SPEED];
		next_clk.initial_osc_sel = ccfg_osc_t'(osc_code);
		next_clk.osc_reserved = (osc_code == 3'h6);
		next_clk.clock_switch_en = ~switch_code[1];
		next_clk.fail_safe_en = (switch_code == 2'h0);
		next_clk.primary_osc_mode = ccfg_pri_t'(posc_code);
		// Pin bit only matters when the oscillator pins are free
		next_clk.clock_out_en = clock_word[CK_OSC_PIN] &
			((posc_code == 2'h3) | (posc_code == 2'h0));
		next_clk.secondary_osc_crystal = prot_word[WP_SECONDARY_OSC];
		next_clk.pll_feed_primary = prot_word[WP_PLL_FEED_SELECT];
	end

	// Protected segment decode; page address is page number shifted up
	always_comb begin
		next_prot.protect_en = ~prot_word[WP_DIS];
		if (prot_word[WP_END]) begin
			next_prot.low_addr = 24'(page) << PAGE_SHIFT;
			next_prot.high_addr = (24'(LAST_PAGE) << PAGE_SHIFT) |
				24'h0003FF;
		end else begin
			next_prot.low_addr = 24'h000000;
			next_prot.high_addr = (24'(page) << PAGE_SHIFT) | 24'h0003FF;
		end
		next_prot.config_page_protected = ~prot_word[WP_DIS] &
			(~prot_word[WP_CFG] | prot_word[WP_END] |
			(page == LAST_PAGE));
		next_prot.brownout_reset_en = prot_word[WP_BOR];
	end

	// Comparator input placement
	always_comb begin
		if (clock_word[CK_ALT_CMP]) begin
			next_cmp.comparator1_c_input = PIN_B13;
			next_cmp.comparator2_c_input = PIN_B9;
			next_cmp.comparator3_c_input = PIN_A0;
		end else begin
			next_cmp.comparator1_c_input = PIN_B9;
			next_cmp.comparator2_c_input = PIN_B9;
			next_cmp.comparator3_c_input = PIN_B9;
		end
	end

	// Decoded outputs are registered and frozen once the load ends;
	// clock settings wait for both words, as two of them live in the
	// protection word
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_CLK_CFG <= '0;
			O_PROT_CFG <= '0;
			O_CMP_CFG <= '0;
		end else if (state == ST_DONE && !load_done_q) begin
			O_CLK_CFG <= next_clk;
			O_PROT_CFG <= next_prot;
			O_CMP_CFG <= next_cmp;
		end
	end

	// Delayed done marks the single capture cycle
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST)
			load_done_q <= 1'b0;
		else
			load_done_q <= O_LOAD_DONE;
	end

	// Watchdog clock source follows live sleep and window state
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_WDOG_CLK <= CCFG_WD_LOW_POWER_RC_OSC;
		end else if (!O_LOAD_DONE || !clock_word[CK_WDOG_MUX]) begin
			O_WDOG_CLK <= CCFG_WD_LOW_POWER_RC_OSC;
		end else begin
			unique case (wdclk_code)
				2'h3: O_WDOG_CLK <= CCFG_WD_LOW_POWER_RC_OSC;
				2'h2: O_WDOG_CLK <= (I_WDOG_WINDOWED && !I_SYS_CLK_IS_LOW_POWER_RC_OSC &&
					!I_SLEEP) ? CCFG_WD_FRC31 : CCFG_WD_LOW_POWER_RC_OSC;
				2'h1: O_WDOG_CLK <= CCFG_WD_SEC;
				2'h0: O_WDOG_CLK <= I_SLEEP ? CCFG_WD_LOW_POWER_RC_OSC : CCFG_WD_SYS;
			endcase
		end
	end

	// Window width in eighths of the period
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_WDOG_WINDOW <= WIN_25;
		end else if (!load_done_q && O_LOAD_DONE) begin
			unique case (win_code)
				2'h3: O_WDOG_WINDOW <= WIN_25;
				2'h2: O_WDOG_WINDOW <= WIN_37;
				2'h1: O_WDOG_WINDOW <= WIN_50;
				2'h0: O_WDOG_WINDOW <= WIN_75;
			endcase
		end
	end

	// PLL feed changes only while the PLL is idle
	assign pll_feed = O_CLK_CFG.pll_feed_primary;
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST)
			O_PLL_FEED_PRIMARY <= 1'b0;
		else if (!I_PLL_IN_USE)
			O_PLL_FEED_PRIMARY <= pll_feed;
	end

endmodule
`default_nettype wire

// file: tb/ccfg_flash_model.sv
// Flash array model serving the decoder's word reads
`timescale 1ns/1ps
`default_nettype none
module ccfg_flash_model
	import ccfg_pkg::*;
(
	// Clock and request
	input wire logic i_clk,
	input wire logic i_rd,
	input wire logic [23:0] i_addr,
	// Stored words and pacing
	input wire logic [23:0] i_clock_word,
	input wire logic [23:0] i_prot_word,
	input wire logic i_slow,
	// Answer
	output logic [23:0] o_data,
	output logic o_valid
);
	logic tick = 1'b0;
	logic ans;
	initial o_valid = 1'b0;
	initial o_data = 24'h000000;
	assign ans = i_rd & ~o_valid & (~i_slow | tick);
	// A gap after each answer lets the address move on; data toggles
	// between answers so a stale word can never pass for a new one
	always @(posedge i_clk) begin
		tick <= ~tick;
		o_valid <= ans;
		o_data <= ~o_data;
		if (ans)
			o_data <= (i_addr == CLOCK_WORD_ADDR) ? i_clock_word : i_prot_word;
	end
endmodule
`default_nettype wire

// file: tb/ccfg_decode_asserts.sv
// Port checks for the config word decoder
`timescale 1ns/1ps
`default_nettype none
module ccfg_decode_asserts
	import ccfg_pkg::*;
(
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// Flash side
	input wire logic [ADDR_WIDTH-1:0] O_FLASH_ADDR,
	input wire logic O_FLASH_RD,
	input wire logic I_FLASH_VALID,
	// Context and results
	input wire logic I_SLEEP,
	input wire logic [CW_WIDTH-1:0] O_CLOCK_WORD,
	input wire logic [CW_WIDTH-1:0] O_PROT_WORD,
	input wire logic O_LOAD_DONE,
	input wire ccfg_clk_t O_CLK_CFG,
	input wire ccfg_wdclk_t O_WDOG_CLK
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	rd_until_done_a: assert property (O_FLASH_RD == !O_LOAD_DONE)
		else $error("read and done disagree");
	prot_take_a: assert property (O_FLASH_RD && I_FLASH_VALID &&
		O_FLASH_ADDR == PROT_WORD_ADDR |=> O_LOAD_DONE) else $error("no done");
	done_hold_a: assert property (O_LOAD_DONE |=> O_LOAD_DONE)
		else $error("done dropped");
	cfg_frozen_a: assert property ($past(O_LOAD_DONE, 2) |->
		$stable(O_CLK_CFG) && $stable(O_CLOCK_WORD)) else $error("cfg moved");
	unimpl_ones_a: assert property (O_CLOCK_WORD[23:16] == 8'hFF &&
		O_PROT_WORD[23:16] == 8'hFF) else $error("upper byte not ones");
	wdog_mux_a: assert property ($past(O_LOAD_DONE, 2) &&
		!O_CLOCK_WORD[CK_WDOG_MUX] |-> O_WDOG_CLK == CCFG_WD_LOW_POWER_RC_OSC)
		else $error("watchdog not on LOW_POWER_RC_OSC");
	wdog_sleep_a: assert property ($past(O_LOAD_DONE, 2) &&
		$past(I_SLEEP) |-> O_WDOG_CLK inside {CCFG_WD_LOW_POWER_RC_OSC, CCFG_WD_SEC})
		else $error("watchdog source in sleep");
	clk_out_a: assert property ($past(O_LOAD_DONE) |->
		O_CLK_CFG.clock_out_en == (O_CLOCK_WORD[5] &&
		O_CLOCK_WORD[1] == O_CLOCK_WORD[0])) else $error("clock out");
	fail_safe_a: assert property ($past(O_LOAD_DONE) |->
		O_CLK_CFG.fail_safe_en == (O_CLOCK_WORD[7:6] == 2'h0))
		else $error("fail-safe");
	// Main scenarios reached
	cover property ($rose(O_LOAD_DONE));
	cover property (O_WDOG_CLK == CCFG_WD_FRC31);
	cover property (O_CLK_CFG.fail_safe_en);
endmodule
bind ccfg_decode ccfg_decode_asserts u_chk (.I_CORE_CLK, .I_RST,
	.O_FLASH_ADDR, .O_FLASH_RD, .I_FLASH_VALID, .I_SLEEP, .O_CLOCK_WORD,
	.O_PROT_WORD, .O_LOAD_DONE, .O_CLK_CFG, .O_WDOG_CLK);
`default_nettype wire

// file: tb/ccfg_decode_bench.sv
// Self-checking bench for the config word decoder
`timescale 1ns/1ps
`default_nettype none
module ccfg_decode_bench;
	import ccfg_pkg::*;
	logic clk = 1'b0, rst = 1'b1, slp = 1'b0, win = 1'b0, lp = 1'b0;
	logic pll = 1'b0, slow = 1'b0, valid, rd, done, feed;
	logic [23:0] addr, data, ocw, opw, ck_w = 24'h0, wp_w = 24'h0;
	logic [2:0] window;
	ccfg_clk_t clkc;
	ccfg_prot_t prot;
	ccfg_cmp_t cmpc;
	ccfg_wdclk_t wdog;
	logic [31:0] e, r;
	logic [31:0] exp_q[$];
	int n_mismatch = 0, check_count = 0, seed = 69271, t;
	logic [2:0] wtab [4] = '{WIN_75, WIN_50, WIN_37, WIN_25};
	ccfg_flash_model u_flash (.i_clk(clk), .i_rd(rd), .i_addr(addr),
		.i_clock_word(ck_w), .i_prot_word(wp_w), .i_slow(slow),
		.o_data(data), .o_valid(valid));
	ccfg_decode u_dut (.I_CORE_CLK(clk), .I_RST(rst), .O_FLASH_ADDR(addr),
		.O_FLASH_RD(rd), .I_FLASH_DATA(data), .I_FLASH_VALID(valid),
		.I_SLEEP(slp), .I_WDOG_WINDOWED(win), .I_SYS_CLK_IS_LOW_POWER_RC_OSC(lp),
		.I_PLL_IN_USE(pll), .O_CLOCK_WORD(ocw), .O_PROT_WORD(opw),
		.O_LOAD_DONE(done), .O_CLK_CFG(clkc), .O_PROT_CFG(prot),
		.O_CMP_CFG(cmpc), .O_WDOG_CLK(wdog), .O_WDOG_WINDOW(window),
		.O_PLL_FEED_PRIMARY(feed));
	always #2.5 clk = ~clk;
	task automatic chk(input string nm, input logic [23:0] ex, ac);
		check_count++;
		if (ex !== ac) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, ex, ac);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function automatic ccfg_clk_t exp_clk(logic [31:0] x);
		return '{x[31], ccfg_osc_t'(x[26:24]), x[26:24] == 3'h6, !x[23],
			x[23:22] == 2'h0, x[21] && x[17] == x[16],
			ccfg_pri_t'(x[17:16]), x[8], x[11]};
	endfunction
	// Sleep wins over every source but secondary; the 31 kHz source needs window mode
	function automatic ccfg_wdclk_t exp_wd(logic [15:0] c, logic [2:0] j);
		if (!c[13] || c[4:3] == 2'h3) return CCFG_WD_LOW_POWER_RC_OSC;
		if (c[4:3] == 2'h1) return CCFG_WD_SEC;
		if (c[4:3] == 2'h0) return j[2] ? CCFG_WD_LOW_POWER_RC_OSC : CCFG_WD_SYS;
		return (j == 3'h2) ? CCFG_WD_FRC31 : CCFG_WD_LOW_POWER_RC_OSC;
	endfunction
	// Eight loads walk every code of the clock word's multi-bit fields and the window field, with a reset between
	initial begin
		repeat (20) @(negedge clk);
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			slow = k[0];
			{slp, win, lp, pll} = 4'h0;
			// Reserved bits kept at one, upper bytes programmed zero
			ck_w = {8'h00, r[15], 1'b0, |k[2:0], r[12], 1'b1, k[2:0],
				k[1:0], r[5], k[2:1], 1'b1, k[1:0]};
			// Large part: top page bit may be set freely
			wp_w = {8'h00, r[31:27], k[1:0], r[26], 1'b1, r[22:16]};
			exp_q.push_back({ck_w[15:0], wp_w[15:0]});
			// Let the flash settle on the new words before release
			repeat (2) @(negedge clk);
			rst <= 1'b0;
			for (t = 0; t < 40 && done !== 1'b1; t++) @(negedge clk);
			if (t == 40) begin
				n_mismatch++;
				break;
			end
			repeat (4) @(negedge clk);
			for (int j = 0; j < 8; j++) begin
				{slp, win, lp} = j[2:0];
				pll = j[0];
				@(negedge clk);
				chk("wdog_clk", exp_wd(ck_w[15:0], j[2:0]), wdog);
				chk("pll_feed", wp_w[11], feed);
			end
			rst <= 1'b1;
			repeat (2) @(negedge clk);
		end
		give_verdict();
	end
	// Each finished load is held against the oldest noted word pair
	initial forever begin
		@(posedge done);
		repeat (3) @(negedge clk);
		e = exp_q.pop_front();
		chk("clock_word", {8'hFF, e[31:16]}, ocw);
		chk("prot_word", {8'hFF, e[15:0]}, opw);
		chk("clk_cfg", exp_clk(e), clkc);
		chk("cmp_cfg", e[28] ? {PIN_B13, PIN_B9, PIN_A0} : {3{PIN_B9}},
			cmpc);
		chk("window", wtab[e[10:9]], window);
		chk("protect_en", !e[13], prot.protect_en);
		chk("brownout", e[12], prot.brownout_reset_en);
		chk("cfg_page", !e[13] && (!e[14] || e[15] || e[6:0] == LAST_PAGE),
			prot.config_page_protected);
		if (!e[13]) chk("low_addr", e[15] ? 24'(e[6:0]) << PAGE_SHIFT :
			24'h0, prot.low_addr);
		chk("high_addr", e[15] ? (24'(LAST_PAGE) << PAGE_SHIFT) | 24'h0003FF :
			(24'(e[6:0]) << PAGE_SHIFT) | 24'h0003FF,
			prot.high_addr);
	end
endmodule
`default_nettype wire
